// ---- hw/ccd_consts.svh ----
// Purpose: Constants for the capture/compare module disable register
// Assumes: 16-bit register reached over a plain strobe port
// Notes:   Included by the package users; definitions only
//
// What this block does
// - Bit 11 set disables capture channel 4; clear leaves it enabled.
// - Bit 10 set disables capture channel 3; clear leaves it enabled.
// - Bits 9 and 8 disable capture channels 2 and 1 when set.
// - Bit 3 clear keeps compare channel 4 enabled; set disables it.
// - Bit 2 set disables compare channel 3; clear leaves it enabled.
// - Bits 1 and 0 disable compare channels 2 and 1 when set.
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

// =====================================================================
// Register map
`define CCD_ADDR_W 4
`define CCD_CTRL_OFFSET 4'h0
`define CCD_CTRL_RESET 16'h0000
`define CCD_CTRL_MASK 16'h0F0F

// =====================================================================
// Field positions
`define CCD_CAP_LSB 8
`define CCD_CMP_LSB 0
`define CCD_DATA_W 16
`define CCD_FIELD_W 4
`define CCD_ALL_CLEAR 16'h0000

// =====================================================================
// Register bit of each channel
`define CCD_CAP4_BIT 11
`define CCD_CAP3_BIT 10
`define CCD_CAP2_BIT 9
`define CCD_CAP1_BIT 8
`define CCD_CMP4_BIT 3
`define CCD_CMP3_BIT 2
`define CCD_CMP2_BIT 1
`define CCD_CMP1_BIT 0

// =====================================================================
// Channel index inside a four-bit group
`define CCD_CH4_IDX 3
`define CCD_CH3_IDX 2
`define CCD_CH2_IDX 1
`define CCD_CH1_IDX 0

`endif

// ---- hw/ccd_pkg.sv ----
// Purpose: Types for the capture/compare module disable register
// Assumes: Nothing beyond the constants header
// Notes:   Disable vectors travel as one packed struct
package ccd_pkg;
    typedef struct packed {
        logic [3:0] captureOff;
        logic [3:0] compareOff;
    } ccd_disable_t;
endpackage : ccd_pkg

// ---- hw/ccd_disable_ctrl.sv ----
// Purpose: Capture/compare module disable control register
// Assumes: Strobes are one cycle long and never both high
// Notes:   Read data stand in the cycle after the read strobe only
`include "ccd_consts.svh"

module ccd_disable_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`CCD_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    output ccd_pkg::ccd_disable_t moduleOff
);

    // =================================================================
    // All checks below run on the system clock and sleep in reset
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // =================================================================
    // Control register
    logic [15:0] capture_compare_disable_ctrl_reg;

    function automatic logic hitCtrl(input logic [`CCD_ADDR_W-1:0] a);
        hitCtrl = (a == `CCD_CTRL_OFFSET);
    endfunction : hitCtrl

    // =================================================================
    // Conversions used only by the checks; the logic calls hitCtrl directly

    // Register image of a disable struct; unused bits stay clear
    function automatic logic [`CCD_DATA_W-1:0] packCtrl(
        input ccd_pkg::ccd_disable_t v
    );
        logic [`CCD_DATA_W-1:0] w;
        w = `CCD_ALL_CLEAR;
        w[`CCD_CAP_LSB +: `CCD_FIELD_W] = v.captureOff;
        w[`CCD_CMP_LSB +: `CCD_FIELD_W] = v.compareOff;
        packCtrl = w;
    endfunction : packCtrl

    // Splits a register image into its two channel groups
    function automatic ccd_pkg::ccd_disable_t unpackCtrl(
        input logic [`CCD_DATA_W-1:0] w
    );
        ccd_pkg::ccd_disable_t v;
        v.captureOff = w[`CCD_CAP_LSB +: `CCD_FIELD_W];
        v.compareOff = w[`CCD_CMP_LSB +: `CCD_FIELD_W];
        unpackCtrl = v;
    endfunction : unpackCtrl

    // Bits with no channel behind them
    function automatic logic [`CCD_DATA_W-1:0] unusedBits(
        input logic [`CCD_DATA_W-1:0] w
    );
        unusedBits = w & ~`CCD_CTRL_MASK;
    endfunction : unusedBits

    // Write strobe aimed at the control word
    function automatic logic ctrlWrite(
        input logic wr,
        input logic [`CCD_ADDR_W-1:0] a
    );
        ctrlWrite = wr && hitCtrl(a);
    endfunction : ctrlWrite

    // Read strobe aimed at the control word
    function automatic logic ctrlRead(
        input logic rd,
        input logic [`CCD_ADDR_W-1:0] a
    );
        ctrlRead = rd && hitCtrl(a);
    endfunction : ctrlRead

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            capture_compare_disable_ctrl_reg <= `CCD_CTRL_RESET;
        end else if (regWrite && hitCtrl(regAddr)) begin
            // Unimplemented bits are masked so they never store
            capture_compare_disable_ctrl_reg <=
                regWdata & `CCD_CTRL_MASK;
        end
    end

    // =================================================================
    // Read port; unmapped addresses and idle cycles return zero
    // Zero outside the read cycle lets several slaves share one
    // return bus through a plain OR, with no multiplexer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= `CCD_ALL_CLEAR;
        end else if (regRead && hitCtrl(regAddr)) begin
            regRdata <= capture_compare_disable_ctrl_reg;
        end else begin
            regRdata <= `CCD_ALL_CLEAR;
        end
    end

    // =================================================================
    // Disable outputs, registered so they come from flip-flops.
    // Loaded from the write data on the same edge as the register, so no extra lag.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            moduleOff <= '0;
        end else if (regWrite && hitCtrl(regAddr)) begin
            // Bits 11..8 map to capture 4..1
            moduleOff.captureOff <= regWdata[`CCD_CAP_LSB +: `CCD_FIELD_W];
            // Bits 3..0 map to compare 4..1
            moduleOff.compareOff <= regWdata[`CCD_CMP_LSB +: `CCD_FIELD_W];
        end
    end

    // =================================================================
    // Per-channel disable views, one name per peripheral module.
    // Wires off the registered struct, so no channel sees a disable
    // before the register holds it.
    logic capture_ch4_off;
    logic capture_ch3_off;
    logic capture_ch2_off;
    logic capture_ch1_off;
    logic compare_ch4_off;
    logic compare_ch3_off;
    logic compare_ch2_off;
    logic compare_ch1_off;

    assign capture_ch4_off = moduleOff.captureOff[`CCD_CH4_IDX];
    assign capture_ch3_off = moduleOff.captureOff[`CCD_CH3_IDX];
    assign capture_ch2_off = moduleOff.captureOff[`CCD_CH2_IDX];
    assign capture_ch1_off = moduleOff.captureOff[`CCD_CH1_IDX];
    assign compare_ch4_off = moduleOff.compareOff[`CCD_CH4_IDX];
    assign compare_ch3_off = moduleOff.compareOff[`CCD_CH3_IDX];
    assign compare_ch2_off = moduleOff.compareOff[`CCD_CH2_IDX];
    assign compare_ch1_off = moduleOff.compareOff[`CCD_CH1_IDX];

    // =================================================================
    // Checks
    AST_CAP4: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regWrite && hitCtrl(regAddr) |=> moduleOff.captureOff[3] ==
            $past(regWdata[11])) else $error("capture 4 disable wrong");
    AST_CAP3: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regWrite && hitCtrl(regAddr) |=> moduleOff.captureOff[2] ==
            $past(regWdata[10])) else $error("capture 3 disable wrong");
    AST_CAP21: assert property (
        regWrite && hitCtrl(regAddr) |=> moduleOff.captureOff[1:0] ==
            $past(regWdata[9:8])) else $error("capture 2/1 disable wrong");
    AST_CMP4: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regWrite && hitCtrl(regAddr) |=> moduleOff.compareOff[3] ==
            $past(regWdata[3])) else $error("compare 4 disable wrong");
    AST_CMP3: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regWrite && hitCtrl(regAddr) |=> moduleOff.compareOff[2] ==
            $past(regWdata[2])) else $error("compare 3 disable wrong");
    AST_CMP21: assert property (
        regWrite && hitCtrl(regAddr) |=> moduleOff.compareOff[1:0] ==
            $past(regWdata[1:0])) else $error("compare 2/1 disable wrong");
    AST_RSVD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRdata & ~`CCD_CTRL_MASK) == `CCD_ALL_CLEAR)
        else $error("reserved bits read nonzero");
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(regWrite && hitCtrl(regAddr)) |=> $stable(moduleOff))
        else $error("disables changed without write");
    AST_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regRead && hitCtrl(regAddr) |=> regRdata ==
            packCtrl(moduleOff))
        else $error("read data mismatch");

    // Each channel view against its register bit
    AST_VIEW_CAP4: assert property (
        capture_ch4_off == capture_compare_disable_ctrl_reg[`CCD_CAP4_BIT])
        else $error("capture 4 view differs from register");
    AST_VIEW_CAP3: assert property (
        capture_ch3_off == capture_compare_disable_ctrl_reg[`CCD_CAP3_BIT])
        else $error("capture 3 view differs from register");
    AST_VIEW_CAP2: assert property (
        capture_ch2_off == capture_compare_disable_ctrl_reg[`CCD_CAP2_BIT])
        else $error("capture 2 view differs from register");
    AST_VIEW_CAP1: assert property (
        capture_ch1_off == capture_compare_disable_ctrl_reg[`CCD_CAP1_BIT])
        else $error("capture 1 view differs from register");
    AST_VIEW_CMP4: assert property (
        compare_ch4_off == capture_compare_disable_ctrl_reg[`CCD_CMP4_BIT])
        else $error("compare 4 view differs from register");
    AST_VIEW_CMP3: assert property (
        compare_ch3_off == capture_compare_disable_ctrl_reg[`CCD_CMP3_BIT])
        else $error("compare 3 view differs from register");
    AST_VIEW_CMP2: assert property (
        compare_ch2_off == capture_compare_disable_ctrl_reg[`CCD_CMP2_BIT])
        else $error("compare 2 view differs from register");
    AST_VIEW_CMP1: assert property (
        compare_ch1_off == capture_compare_disable_ctrl_reg[`CCD_CMP1_BIT])
        else $error("compare 1 view differs from register");

    // A channel view moves only on a control write
    AST_KEEP_CAP4: assert property (
        !ctrlWrite(regWrite, regAddr) |=> $stable(capture_ch4_off))
        else $error("capture 4 disable moved without write");
    AST_KEEP_CAP3: assert property (
        !ctrlWrite(regWrite, regAddr) |=> $stable(capture_ch3_off))
        else $error("capture 3 disable moved without write");
    AST_KEEP_CAP2: assert property (
        !ctrlWrite(regWrite, regAddr) |=> $stable(capture_ch2_off))
        else $error("capture 2 disable moved without write");
    AST_KEEP_CAP1: assert property (
        !ctrlWrite(regWrite, regAddr) |=> $stable(capture_ch1_off))
        else $error("capture 1 disable moved without write");
    AST_KEEP_CMP4: assert property (
        !ctrlWrite(regWrite, regAddr) |=> $stable(compare_ch4_off))
        else $error("compare 4 disable moved without write");
    AST_KEEP_CMP3: assert property (
        !ctrlWrite(regWrite, regAddr) |=> $stable(compare_ch3_off))
        else $error("compare 3 disable moved without write");
    AST_KEEP_CMP2: assert property (
        !ctrlWrite(regWrite, regAddr) |=> $stable(compare_ch2_off))
        else $error("compare 2 disable moved without write");
    AST_KEEP_CMP1: assert property (
        !ctrlWrite(regWrite, regAddr) |=> $stable(compare_ch1_off))
        else $error("compare 1 disable moved without write");

    // Views follow the written bits one edge later
    AST_FOLLOW_CAP: assert property (
        ctrlWrite(regWrite, regAddr) |=> {capture_ch4_off, capture_ch3_off,
            capture_ch2_off, capture_ch1_off} ==
            $past(regWdata[`CCD_CAP_LSB +: `CCD_FIELD_W]))
        else $error("capture views do not follow write");
    AST_FOLLOW_CMP: assert property (
        ctrlWrite(regWrite, regAddr) |=> {compare_ch4_off, compare_ch3_off,
            compare_ch2_off, compare_ch1_off} ==
            $past(regWdata[`CCD_CMP_LSB +: `CCD_FIELD_W]))
        else $error("compare views do not follow write");

    // Read data of every channel bit against its view
    AST_RB_CAP4: assert property (
        ctrlRead(regRead, regAddr) |=> regRdata[`CCD_CAP4_BIT] ==
            capture_ch4_off)
        else $error("capture 4 read back wrong");
    AST_RB_CAP3: assert property (
        ctrlRead(regRead, regAddr) |=> regRdata[`CCD_CAP3_BIT] ==
            capture_ch3_off)
        else $error("capture 3 read back wrong");
    AST_RB_CAP2: assert property (
        ctrlRead(regRead, regAddr) |=> regRdata[`CCD_CAP2_BIT] ==
            capture_ch2_off)
        else $error("capture 2 read back wrong");
    AST_RB_CAP1: assert property (
        ctrlRead(regRead, regAddr) |=> regRdata[`CCD_CAP1_BIT] ==
            capture_ch1_off)
        else $error("capture 1 read back wrong");
    AST_RB_CMP4: assert property (
        ctrlRead(regRead, regAddr) |=> regRdata[`CCD_CMP4_BIT] ==
            compare_ch4_off)
        else $error("compare 4 read back wrong");
    AST_RB_CMP3: assert property (
        ctrlRead(regRead, regAddr) |=> regRdata[`CCD_CMP3_BIT] ==
            compare_ch3_off)
        else $error("compare 3 read back wrong");
    AST_RB_CMP2: assert property (
        ctrlRead(regRead, regAddr) |=> regRdata[`CCD_CMP2_BIT] ==
            compare_ch2_off)
        else $error("compare 2 read back wrong");
    AST_RB_CMP1: assert property (
        ctrlRead(regRead, regAddr) |=> regRdata[`CCD_CMP1_BIT] ==
            compare_ch1_off)
        else $error("compare 1 read back wrong");

    // Whole-word behaviour of the register and the read port
    AST_SHADOW: assert property (
        moduleOff == unpackCtrl(capture_compare_disable_ctrl_reg))
        else $error("disable outputs differ from register");
    AST_STORE: assert property (
        ctrlWrite(regWrite, regAddr) |=>
            capture_compare_disable_ctrl_reg ==
            ($past(regWdata) & `CCD_CTRL_MASK))
        else $error("write stored wrong value");
    AST_KEEP: assert property (
        !ctrlWrite(regWrite, regAddr) |=>
            $stable(capture_compare_disable_ctrl_reg))
        else $error("register changed without write");
    AST_UNUSED: assert property (
        unusedBits(capture_compare_disable_ctrl_reg) == `CCD_ALL_CLEAR)
        else $error("unused bits stored");
    AST_RD_IDLE: assert property (
        !ctrlRead(regRead, regAddr) |=> regRdata == `CCD_ALL_CLEAR)
        else $error("read data outside read cycle");
    AST_RD_HI: assert property (
        regRdata[`CCD_CAP_LSB + `CCD_FIELD_W +: `CCD_FIELD_W] == '0)
        else $error("upper unused nibble reads nonzero");
    AST_RD_MID: assert property (
        regRdata[`CCD_CMP_LSB + `CCD_FIELD_W +: `CCD_FIELD_W] == '0)
        else $error("middle unused nibble reads nonzero");

    // First edge after reset: everything still clear, every channel on
    AST_RST_OFF: assert property (
        !$past(rst_n) |-> packCtrl(moduleOff) == `CCD_ALL_CLEAR)
        else $error("channels not enabled after reset");
    AST_RST_REG: assert property (
        !$past(rst_n) |->
            capture_compare_disable_ctrl_reg == `CCD_CTRL_RESET)
        else $error("register not clear after reset");
    AST_RST_RD: assert property (
        !$past(rst_n) |-> regRdata == `CCD_ALL_CLEAR)
        else $error("read data not clear after reset");

    COV_WRITE: cover property (@(posedge clk_sys) disable iff (!rst_n)
        regWrite && hitCtrl(regAddr) && regWdata[11]);
    COV_READ: cover property (@(posedge clk_sys) disable iff (!rst_n)
        regRead && hitCtrl(regAddr) ##1 regRdata != `CCD_ALL_CLEAR);
    COV_BACK: cover property (@(posedge clk_sys) disable iff (!rst_n)
        regWrite && hitCtrl(regAddr) ##1 regRead && hitCtrl(regAddr));
    COV_UNMAPPED: cover property (
        regWrite && !hitCtrl(regAddr));
    COV_UNUSED: cover property (
        ctrlWrite(regWrite, regAddr) &&
        unusedBits(regWdata) != `CCD_ALL_CLEAR);

endmodule : ccd_disable_ctrl

// ---- tb/capture_compare_module_disable_test.sv ----
// Purpose: Bench for the capture/compare disable register
// Assumes: Register at offset 0x0, one clock, async reset
// Notes:   Directed tasks, no random stimulus
module capture_compare_module_disable_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdata;
    ccd_pkg::ccd_disable_t moduleOff;
    int miscompares = 0;
    int samples_checked = 0;
    logic [15:0] d, e;
    logic [7:0] o;
    ccd_disable_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .moduleOff(moduleOff));
    // ====================================================
    // Bus tasks, entered just after a rising edge
    task automatic chk(string nm, logic [15:0] s, logic [15:0] x);
        samples_checked++;
        if (s !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [15:0] v);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    // Read data stand one cycle only, so sample mid-cycle
    task automatic rd(logic [3:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        d = regRdata;
        o = moduleOff;
        @(posedge clk_sys);
    endtask : rd
    // ====================================================
    // Scenarios
    task automatic walk_bits();
        for (int i = 0; i < 16; i++) begin
            e = (16'h0001 << i) & 16'h0F0F;
            wr(4'h0, 16'h0001 << i);
            rd(4'h0);
            chk("ctrl", d, e);
            chk("off", {8'h00, o}, {8'h00, e[11:8], e[3:0]});
        end
    endtask : walk_bits
    task automatic unmapped();
        wr(4'h0, 16'hFFFF);
        wr(4'hF, 16'h0000);
        rd(4'hF);
        chk("unmapped", d, 16'h0000);
        chk("kept", {8'h00, o}, 16'h00FF);
    endtask : unmapped
    task automatic reset_mid();
        rst_n <= 1'b0;
        @(negedge clk_sys);
        chk("rstoff", {8'h00, moduleOff}, 16'h0000);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(4'h0);
        chk("rstctrl", d, 16'h0000);
    endtask : reset_mid
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        walk_bits();
        unmapped();
        reset_mid();
        end_sim();
    end
    // Run needs about 60 cycles; allow far more before giving up
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end
endmodule : capture_compare_module_disable_test
